// ---- logic/aicl_monitor.sv ----
// analog input correction chain, limit comparators and avalon register slave
//
// Summary of operation
// R1 - each channel has two independent limit comparators with own results
// R2 - limits are signed 16-bit values, full range 0x8000 to 0x7fff
// R3 - after reset both limit comparisons are off on every channel
// R4 - each limit comparison has its own enable bit
// R5 - disabled comparison reports code 0
// R6 - no swap: code 1 when value below limit, 2 when above
// R7 - swap: code 1 when value above limit, 2 when below
// R8 - value equal to limit reports code 3 regardless of swap
// R9 - swap setting is false after reset
// R10 - comparison follows the most recent value every cycle
// R11 - factory stage gain*(x-offset), coefficients per measuring range
// R12 - factory coefficients are readable, writes to them are ignored
// R13 - factory stage per channel enable, cleared means bypass
// R14 - optional user correction stage gain*(x-offset)
// R15 - user correction bypassed after reset, enabled per channel
// R16 - user correction offset and gain are writable per channel
// R17 - over and under flags use the value after user correction
// R18 - optional user scaling stage gain*(x-offset)
// R19 - user scaling bypassed after reset, enabled per channel
// R20 - scaling offset and gain are writable per channel
// R21 - order factory, user correction, scaling, then comparison on final value
// R22 - stages use fixed-point gain and saturate to signed 16 bits
`timescale 1ns/1ps
module aicl_monitor #(
  parameter int NUM_CH = 4,
  parameter logic signed [15:0] FACT_OFS [NUM_CH][aicl_pkg::NUM_RANGES] =
    '{default: aicl_pkg::OFS_RST},
  parameter logic signed [15:0] FACT_GAIN [NUM_CH][aicl_pkg::NUM_RANGES] =
    '{default: aicl_pkg::GAIN_ONE}
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire aicl_pkg::aicl_sample_s sample_in,
  output aicl_pkg::aicl_pd_s [NUM_CH-1:0] pd_out
);

  if (NUM_CH < 1 || NUM_CH > aicl_pkg::MAX_CH)
  begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 4");
  end

  localparam logic [2:0] NCH = 3'(NUM_CH);

  logic [15:0] ctrl_r [NUM_CH];
  logic signed [15:0] lim1_r [NUM_CH];
  logic signed [15:0] lim2_r [NUM_CH];
  logic signed [15:0] uofs_r [NUM_CH];
  logic signed [15:0] ugain_r [NUM_CH];
  logic signed [15:0] sofs_r [NUM_CH];
  logic signed [15:0] sgain_r [NUM_CH];
  logic signed [15:0] value_r [NUM_CH];
  logic over_r [NUM_CH];
  logic under_r [NUM_CH];
  aicl_pkg::aicl_code_e code1_r [NUM_CH];
  aicl_pkg::aicl_code_e code2_r [NUM_CH];
  logic ack_r;
  logic [31:0] rdata_r;

  // gain is q2.14; the wide product is clipped instead of wrapped
  function automatic logic signed [15:0] stage_f(input logic signed [15:0] x,
                                                 input logic signed [15:0] ofs,
                                                 input logic signed [15:0] gain,
                                                 input logic en);
    logic signed [16:0] d;
    logic signed [32:0] p;
    logic signed [32:0] q;
    d = 17'(x) - 17'(ofs);
    p = 33'(d) * 33'(gain); // [R22]
    q = p >>> aicl_pkg::GAIN_FRAC;
    if (!en)
      stage_f = x;
    else if (q > 33'(aicl_pkg::SAT_MAX))
      stage_f = aicl_pkg::SAT_MAX; // [R22]
    else if (q < 33'(aicl_pkg::SAT_MIN))
      stage_f = aicl_pkg::SAT_MIN; // [R22]
    else
      stage_f = q[15:0];
  endfunction

  function automatic aicl_pkg::aicl_code_e cmp_f(input logic signed [15:0] v,
                                                 input logic signed [15:0] thr,
                                                 input logic en,
                                                 input logic swap);
    if (!en)
      cmp_f = aicl_pkg::LIM_OFF; // [R5]
    else if (v == thr)
      cmp_f = aicl_pkg::LIM_EQ; // [R8]
    else if ((v < thr) != swap)
      cmp_f = aicl_pkg::LIM_LOW; // [R6] [R7]
    else
      cmp_f = aicl_pkg::LIM_HIGH; // [R6] [R7]
  endfunction

  function automatic logic [15:0] merge_f(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    merge_f = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [31:0] ext_f(input logic [15:0] v);
    ext_f = {16'h0000, v};
  endfunction

  // bus decode
  wire logic req = avs_read_in | avs_write_in;
  wire logic [1:0] acc_ch = avs_address_in[7:aicl_pkg::CH_LSB];
  wire logic [5:0] acc_ofs = avs_address_in[5:0];
  wire logic ch_ok = {1'b0, acc_ch} < NCH;
  // factory offsets are absent here on purpose, so writes to them fall through
  wire logic wr_go = avs_write_in & ack_r & ch_ok; // [R12]

  // one wait cycle per access; the read word is captured in that cycle
  assign avs_waitrequest_out = req & ~ack_r;
  assign avs_readdata_out = rdata_r;

  function automatic logic [31:0] rd_f(input logic [1:0] ch, input logic [5:0] ofs);
    rd_f = 32'h0000_0000;
    unique case (ofs)
      aicl_pkg::OFS_CTRL: rd_f = ext_f(ctrl_r[ch]);
      aicl_pkg::OFS_LIM1: rd_f = ext_f(lim1_r[ch]);
      aicl_pkg::OFS_LIM2: rd_f = ext_f(lim2_r[ch]);
      aicl_pkg::OFS_UOFS: rd_f = ext_f(uofs_r[ch]);
      aicl_pkg::OFS_UGAIN: rd_f = ext_f(ugain_r[ch]);
      aicl_pkg::OFS_SOFS: rd_f = ext_f(sofs_r[ch]);
      aicl_pkg::OFS_SGAIN: rd_f = ext_f(sgain_r[ch]);
      aicl_pkg::OFS_FOFS0: rd_f = ext_f(FACT_OFS[ch][0]); // [R12]
      aicl_pkg::OFS_FGAIN0: rd_f = ext_f(FACT_GAIN[ch][0]); // [R12]
      aicl_pkg::OFS_FOFS1: rd_f = ext_f(FACT_OFS[ch][1]); // [R12]
      aicl_pkg::OFS_FGAIN1: rd_f = ext_f(FACT_GAIN[ch][1]); // [R12]
      aicl_pkg::OFS_STAT: rd_f = {10'h000, under_r[ch], over_r[ch],
                                  code2_r[ch], code1_r[ch], value_r[ch]};
      default: rd_f = 32'h0000_0000;
    endcase
  endfunction

  // read word is captured once at the edge ending the wait cycle, so later changes behind a held address are not seen
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (avs_read_in & ~ack_r)
        rdata_r <= ch_ok ? rd_f(acc_ch, acc_ofs) : 32'h0000_0000;
    end
  end

  // correction chain on the arriving sample
  wire logic [1:0] s_ch = sample_in.chan;
  wire logic s_ok = sample_in.valid & ({1'b0, s_ch} < NCH);
  wire logic [15:0] s_ctrl = s_ok ? ctrl_r[s_ch] : aicl_pkg::CTRL_RST;
  wire logic s_rng = s_ctrl[aicl_pkg::CTRL_RANGE];
  wire logic signed [15:0] f_ofs = s_ok ? FACT_OFS[s_ch][s_rng] : aicl_pkg::OFS_RST;
  wire logic signed [15:0] f_gain = s_ok ? FACT_GAIN[s_ch][s_rng] : aicl_pkg::GAIN_ONE;
  wire logic signed [15:0] u_ofs = s_ok ? uofs_r[s_ch] : aicl_pkg::OFS_RST;
  wire logic signed [15:0] u_gain = s_ok ? ugain_r[s_ch] : aicl_pkg::GAIN_ONE;
  wire logic signed [15:0] c_ofs = s_ok ? sofs_r[s_ch] : aicl_pkg::OFS_RST;
  wire logic signed [15:0] c_gain = s_ok ? sgain_r[s_ch] : aicl_pkg::GAIN_ONE;
  wire logic signed [15:0] v_fact = stage_f(sample_in.value, f_ofs, f_gain,
                                            s_ctrl[aicl_pkg::CTRL_FCAL_EN]); // [R11] [R13]
  wire logic signed [15:0] v_user = stage_f(v_fact, u_ofs, u_gain,
                                            s_ctrl[aicl_pkg::CTRL_UCAL_EN]); // [R14] [R21]
  wire logic signed [15:0] v_scl = stage_f(v_user, c_ofs, c_gain,
                                           s_ctrl[aicl_pkg::CTRL_SCL_EN]); // [R18] [R21]
  // range flags look at the corrected value, before scaling alters the units
  wire logic v_over = v_user > aicl_pkg::NOM_HI; // [R17]
  wire logic v_under = v_user < aicl_pkg::NOM_LO; // [R17]

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    wire logic sel = wr_go & (acc_ch == 2'(c));
    wire logic [15:0] ctrl_nxt = merge_f(ctrl_r[c], avs_writedata_in,
                                         avs_byteenable_in) & aicl_pkg::CTRL_MASK;
    wire logic hit = s_ok & (s_ch == 2'(c));

    always_ff @(posedge ref_clk_in)
    begin
      if (reset_in)
      begin
        ctrl_r[c] <= aicl_pkg::CTRL_RST; // [R3] [R9] [R15] [R19]
        lim1_r[c] <= aicl_pkg::LIM_RST;
        lim2_r[c] <= aicl_pkg::LIM_RST;
        uofs_r[c] <= aicl_pkg::OFS_RST;
        ugain_r[c] <= aicl_pkg::GAIN_ONE;
        sofs_r[c] <= aicl_pkg::OFS_RST;
        sgain_r[c] <= aicl_pkg::GAIN_ONE;
      end
      else if (sel)
      begin
        if (acc_ofs == aicl_pkg::OFS_CTRL)
          ctrl_r[c] <= ctrl_nxt; // [R4] [R13] [R15] [R19]
        if (acc_ofs == aicl_pkg::OFS_LIM1)
          lim1_r[c] <= merge_f(lim1_r[c], avs_writedata_in, avs_byteenable_in); // [R2]
        if (acc_ofs == aicl_pkg::OFS_LIM2)
          lim2_r[c] <= merge_f(lim2_r[c], avs_writedata_in, avs_byteenable_in); // [R2]
        if (acc_ofs == aicl_pkg::OFS_UOFS)
          uofs_r[c] <= merge_f(uofs_r[c], avs_writedata_in, avs_byteenable_in); // [R16]
        if (acc_ofs == aicl_pkg::OFS_UGAIN)
          ugain_r[c] <= merge_f(ugain_r[c], avs_writedata_in, avs_byteenable_in); // [R16]
        if (acc_ofs == aicl_pkg::OFS_SOFS)
          sofs_r[c] <= merge_f(sofs_r[c], avs_writedata_in, avs_byteenable_in); // [R20]
        if (acc_ofs == aicl_pkg::OFS_SGAIN)
          sgain_r[c] <= merge_f(sgain_r[c], avs_writedata_in, avs_byteenable_in); // [R20]
      end
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (reset_in)
      begin
        value_r[c] <= 16'sh0000;
        over_r[c] <= 1'b0;
        under_r[c] <= 1'b0;
        code1_r[c] <= aicl_pkg::LIM_OFF;
        code2_r[c] <= aicl_pkg::LIM_OFF;
      end
      else
      begin
        if (hit)
        begin
          value_r[c] <= v_scl; // [R21]
          over_r[c] <= v_over; // [R17]
          under_r[c] <= v_under; // [R17]
        end
        // recomputed every cycle so limit or enable changes show one cycle later, without a new sample
        code1_r[c] <= cmp_f(value_r[c], lim1_r[c], ctrl_r[c][aicl_pkg::CTRL_LIM1_EN],
                            ctrl_r[c][aicl_pkg::CTRL_SWAP]); // [R1] [R10]
        code2_r[c] <= cmp_f(value_r[c], lim2_r[c], ctrl_r[c][aicl_pkg::CTRL_LIM2_EN],
                            ctrl_r[c][aicl_pkg::CTRL_SWAP]); // [R1] [R10]
      end
    end

    assign pd_out[c] = '{value: value_r[c], lim1: code1_r[c], lim2: code2_r[c],
                         over: over_r[c], under: under_r[c]};

    property p_off_code;
      @(posedge ref_clk_in) disable iff (reset_in)
      !ctrl_r[c][aicl_pkg::CTRL_LIM1_EN] |=> code1_r[c] == aicl_pkg::LIM_OFF;
    endproperty
    a_off_code: assert property (p_off_code) else $error("disabled limit not zero"); // [R5]

    property p_below;
      @(posedge ref_clk_in) disable iff (reset_in)
      ctrl_r[c][aicl_pkg::CTRL_LIM1_EN] && !ctrl_r[c][aicl_pkg::CTRL_SWAP]
        && value_r[c] < lim1_r[c] |=> code1_r[c] == aicl_pkg::LIM_LOW;
    endproperty
    a_below: assert property (p_below) else $error("below limit not code 1"); // [R6]

    property p_swap_above;
      @(posedge ref_clk_in) disable iff (reset_in)
      ctrl_r[c][aicl_pkg::CTRL_LIM2_EN] && ctrl_r[c][aicl_pkg::CTRL_SWAP]
        && value_r[c] > lim2_r[c] |=> code2_r[c] == aicl_pkg::LIM_LOW;
    endproperty
    a_swap_above: assert property (p_swap_above) else $error("swapped above not 1"); // [R7]

    property p_equal;
      @(posedge ref_clk_in) disable iff (reset_in)
      ctrl_r[c][aicl_pkg::CTRL_LIM2_EN] && value_r[c] == lim2_r[c]
        |=> code2_r[c] == aicl_pkg::LIM_EQ;
    endproperty
    a_equal: assert property (p_equal) else $error("equal value not code 3"); // [R8]

    property p_reset_off;
      @(posedge ref_clk_in)
      $fell(reset_in) |-> ctrl_r[c] == aicl_pkg::CTRL_RST
        ##1 code1_r[c] == aicl_pkg::LIM_OFF && code2_r[c] == aicl_pkg::LIM_OFF;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("not off after reset"); // [R3]

    property p_wr_uofs;
      @(posedge ref_clk_in) disable iff (reset_in)
      sel && acc_ofs == aicl_pkg::OFS_UOFS && avs_byteenable_in[1:0] == 2'b11
        |=> uofs_r[c] == $past(avs_writedata_in[15:0]);
    endproperty
    a_wr_uofs: assert property (p_wr_uofs) else $error("user offset not stored"); // [R16]

    property p_off_code2;
      @(posedge ref_clk_in) disable iff (reset_in)
      !ctrl_r[c][aicl_pkg::CTRL_LIM2_EN] |=> code2_r[c] == aicl_pkg::LIM_OFF;
    endproperty
    a_off_code2: assert property (p_off_code2) else $error("limit 2 off not zero"); // [R5]

    property p_above;
      @(posedge ref_clk_in) disable iff (reset_in)
      ctrl_r[c][aicl_pkg::CTRL_LIM1_EN] && !ctrl_r[c][aicl_pkg::CTRL_SWAP]
        && value_r[c] > lim1_r[c] |=> code1_r[c] == aicl_pkg::LIM_HIGH;
    endproperty
    a_above: assert property (p_above) else $error("above limit not code 2"); // [R6]

    property p_swap_below;
      @(posedge ref_clk_in) disable iff (reset_in)
      ctrl_r[c][aicl_pkg::CTRL_LIM2_EN] && ctrl_r[c][aicl_pkg::CTRL_SWAP]
        && value_r[c] < lim2_r[c] |=> code2_r[c] == aicl_pkg::LIM_HIGH;
    endproperty
    a_swap_below: assert property (p_swap_below) else $error("swapped below not 2"); // [R7]

    property p_equal1;
      @(posedge ref_clk_in) disable iff (reset_in)
      ctrl_r[c][aicl_pkg::CTRL_LIM1_EN] && value_r[c] == lim1_r[c]
        |=> code1_r[c] == aicl_pkg::LIM_EQ;
    endproperty
    a_equal1: assert property (p_equal1) else $error("equal limit 1 not code 3"); // [R8]

    property p_wr_lim1;
      @(posedge ref_clk_in) disable iff (reset_in)
      sel && acc_ofs == aicl_pkg::OFS_LIM1 && avs_byteenable_in[1:0] == 2'b11
        |=> lim1_r[c] == $past(avs_writedata_in[15:0]);
    endproperty
    a_wr_lim1: assert property (p_wr_lim1) else $error("limit 1 not stored"); // [R2]

    property p_wr_sgain;
      @(posedge ref_clk_in) disable iff (reset_in)
      sel && acc_ofs == aicl_pkg::OFS_SGAIN && avs_byteenable_in[1:0] == 2'b11
        |=> sgain_r[c] == $past(avs_writedata_in[15:0]);
    endproperty
    a_wr_sgain: assert property (p_wr_sgain) else $error("scale gain not stored"); // [R20]

    property p_wr_ctrl;
      @(posedge ref_clk_in) disable iff (reset_in)
      sel && acc_ofs == aicl_pkg::OFS_CTRL && avs_byteenable_in[1:0] == 2'b11
        |=> ctrl_r[c] == ($past(avs_writedata_in[15:0]) & aicl_pkg::CTRL_MASK);
    endproperty
    a_wr_ctrl: assert property (p_wr_ctrl) else $error("control not stored"); // [R4]

    property p_range_flags;
      @(posedge ref_clk_in) disable iff (reset_in)
      hit && !ctrl_r[c][aicl_pkg::CTRL_SCL_EN]
        |=> over_r[c] == (value_r[c] > aicl_pkg::NOM_HI)
        && under_r[c] == (value_r[c] < aicl_pkg::NOM_LO);
    endproperty
    a_range_flags: assert property (p_range_flags) else $error("range flag mismatch"); // [R17]
  end

  sequence s_wait;
    req && avs_waitrequest_out;
  endsequence

  sequence s_done;
    !avs_waitrequest_out;
  endsequence

  property p_bus_answer;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_wait |=> s_done;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_fact_read;
    @(posedge ref_clk_in) disable iff (reset_in)
    avs_read_in && ack_r && ch_ok && acc_ofs == aicl_pkg::OFS_FGAIN0
      |-> avs_readdata_out == ext_f(FACT_GAIN[acc_ch][0]);
  endproperty
  a_fact_read: assert property (p_fact_read) else $error("factory gain misread"); // [R12]

  property p_fofs_read;
    @(posedge ref_clk_in) disable iff (reset_in)
    avs_read_in && ack_r && ch_ok && acc_ofs == aicl_pkg::OFS_FOFS0
      |-> avs_readdata_out == ext_f(FACT_OFS[acc_ch][0]);
  endproperty
  a_fofs_read: assert property (p_fofs_read) else $error("factory offset misread"); // [R12]

  property p_bypass;
    @(posedge ref_clk_in) disable iff (reset_in)
    s_ok && s_ctrl[aicl_pkg::CTRL_FCAL_EN:aicl_pkg::CTRL_UCAL_EN] == 2'b00
      && !s_ctrl[aicl_pkg::CTRL_SCL_EN]
      |=> value_r[$past(s_ch)] == $past(sample_in.value);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed value altered"); // [R15]

endmodule

// ---- include/aicl_pkg.sv ----
// constants and carriers for the analog input calibration and limit monitor
package aicl_pkg;
  localparam int MAX_CH = 4;
  localparam int NUM_RANGES = 2;
  localparam int GAIN_FRAC = 14;
  localparam logic signed [15:0] GAIN_ONE = 16'sh4000;
  localparam logic signed [15:0] SAT_MAX = 16'sh7fff;
  localparam logic signed [15:0] SAT_MIN = 16'sh8000;
  localparam logic signed [15:0] NOM_HI = 16'sh7530;
  localparam logic signed [15:0] NOM_LO = 16'sh8ad0;
  // byte offsets inside one channel window; channel number sits in address bits 7:6
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_LIM1 = 6'h04;
  localparam logic [5:0] OFS_LIM2 = 6'h08;
  localparam logic [5:0] OFS_UOFS = 6'h0c;
  localparam logic [5:0] OFS_UGAIN = 6'h10;
  localparam logic [5:0] OFS_SOFS = 6'h14;
  localparam logic [5:0] OFS_SGAIN = 6'h18;
  localparam logic [5:0] OFS_FOFS0 = 6'h1c;
  localparam logic [5:0] OFS_FGAIN0 = 6'h20;
  localparam logic [5:0] OFS_FOFS1 = 6'h24;
  localparam logic [5:0] OFS_FGAIN1 = 6'h28;
  localparam logic [5:0] OFS_STAT = 6'h2c;
  localparam int CH_LSB = 6;
  // control register fields
  localparam int CTRL_SCL_EN = 0;
  localparam int CTRL_LIM1_EN = 1;
  localparam int CTRL_LIM2_EN = 2;
  localparam int CTRL_UCAL_EN = 3;
  localparam int CTRL_FCAL_EN = 4;
  localparam int CTRL_SWAP = 5;
  localparam int CTRL_RANGE = 8;
  localparam logic [15:0] CTRL_MASK = 16'h013f;
  localparam logic [15:0] CTRL_RST = 16'h0010;
  localparam logic signed [15:0] LIM_RST = 16'sh0000;
  localparam logic signed [15:0] OFS_RST = 16'sh0000;
  // status word fields
  localparam int STAT_LIM1 = 16;
  localparam int STAT_LIM2 = 18;
  localparam int STAT_OVER = 20;
  localparam int STAT_UNDER = 21;

  typedef enum logic [1:0] {
    LIM_OFF = 2'b00,
    LIM_LOW = 2'b01,
    LIM_HIGH = 2'b10,
    LIM_EQ = 2'b11
  } aicl_code_e;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic signed [15:0] value;
  } aicl_sample_s;

  typedef struct packed {
    logic signed [15:0] value;
    aicl_code_e lim1;
    aicl_code_e lim2;
    logic over;
    logic under;
  } aicl_pd_s;
endpackage

// ---- verification/aicl_ctrl_model.sv ----
// fieldbus controller model: avalon master issuing parameter reads and writes
`timescale 1ns/1ps
module aicl_ctrl_model (
  input wire logic clk_in,
  input wire logic waitrequest_in,
  input wire logic [31:0] readdata_in,
  output logic [7:0] address_out,
  output logic read_out,
  output logic write_out,
  output logic [31:0] writedata_out,
  output logic [3:0] byteenable_out
);
  int timeouts = 0;

  initial
  begin
    address_out = 8'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0000_0000;
    byteenable_out = 4'h0;
  end

  // request stays put until waitrequest is seen low at a rising edge, or for at most 64 edges
  task automatic wait_ack();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (waitrequest_in !== 1'b0 && n < 64);
    if (waitrequest_in !== 1'b0)
      timeouts++;
  endtask

  // settings travel as signed 16-bit words in bits 15:0
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    address_out <= a;
    writedata_out <= {16'h0000, d};
    byteenable_out <= 4'hf;
    write_out <= 1'b1;
    wait_ack();
    write_out <= 1'b0;
    // released lines show garbage, not the last value
    address_out <= ~a;
    writedata_out <= ~{16'h0000, d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    address_out <= a;
    byteenable_out <= 4'hf;
    read_out <= 1'b1;
    wait_ack();
    d = readdata_in;
    read_out <= 1'b0;
    address_out <= ~a;
  endtask
endmodule

// ---- verification/test_aicl_monitor.sv ----
// self-checking bench for the analog input correction and limit monitor
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
    end \
  end
module test_aicl_monitor;
  logic ref_clk_in;
  logic reset_in;
  logic [7:0] adr;
  logic rd_en;
  logic wr_en;
  logic wreq;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] d;
  logic [3:0] be;
  aicl_pkg::aicl_sample_s smp;
  aicl_pkg::aicl_pd_s [3:0] pd;
  logic signed [15:0] vals [4] = '{16'sd100, 16'sd50, 16'sd200, 16'sh8000};
  int n_errors = 0;
  int compares = 0;

  // range 1 factory gain is one half on every channel
  aicl_monitor #(
    .NUM_CH(4),
    .FACT_GAIN('{4{'{16'sh4000, 16'sh2000}}})
  ) uut (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .avs_address_in(adr),
    .avs_read_in(rd_en),
    .avs_write_in(wr_en),
    .avs_writedata_in(wdat),
    .avs_byteenable_in(be),
    .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq),
    .sample_in(smp),
    .pd_out(pd)
  );

  aicl_ctrl_model bus (
    .clk_in(ref_clk_in),
    .waitrequest_in(wreq),
    .readdata_in(rdat),
    .address_out(adr),
    .read_out(rd_en),
    .write_out(wr_en),
    .writedata_out(wdat),
    .byteenable_out(be)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one stage: floor of (x - o) * g / 2^14, clipped to 16 bits
  function automatic logic signed [15:0] stg(input logic signed [15:0] x,
    input logic signed [15:0] o, input logic signed [15:0] g, input bit en);
    longint p;
    if (!en)
      return x;
    p = (longint'(x) - longint'(o)) * longint'(g);
    p = p >>> 14;
    if (p > 32767)
      p = 32767;
    if (p < -32768)
      p = -32768;
    return p[15:0];
  endfunction

  function automatic logic [1:0] cde(input logic signed [15:0] v,
    input logic signed [15:0] l, input bit sw);
    if (v == l)
      return 2'h3;
    return ((v < l) ^ sw) ? 2'h1 : 2'h2;
  endfunction

  // one sample, then value and both codes once the limit stage has settled
  task automatic feed(input logic [1:0] ch, input logic signed [15:0] x,
    input logic signed [15:0] ev, input logic [1:0] c1, input logic [1:0] c2);
    @(posedge ref_clk_in);
    smp <= '{valid: 1'b1, chan: ch, value: x};
    @(posedge ref_clk_in);
    smp <= '{valid: 1'b0, chan: ~ch, value: ~x};
    repeat (2) @(posedge ref_clk_in);
    #1;
    `CHK("value", ev, pd[ch].value)
    `CHK("limit1", c1, 2'(pd[ch].lim1))
    `CHK("limit2", c2, 2'(pd[ch].lim2))
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus.rd(a, d);
    `CHK("register", e, d)
  endtask

  // a stuck bus request ends the run
  always @(posedge ref_clk_in)
    if (bus.timeouts != 0)
    begin
      n_errors++;
      tally_and_finish();
    end

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    reset_in = 1'b1;
    smp = '0;
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    `CHK("process data", 88'h0, pd)
    for (int c = 0; c < 4; c++)
      rchk({c[1:0], aicl_pkg::OFS_CTRL}, 32'h0000_0010);
    bus.wr({2'h0, aicl_pkg::OFS_FOFS0}, 16'h1234);
    rchk({2'h0, aicl_pkg::OFS_FOFS0}, 32'h0000_0000);
    rchk({2'h0, aicl_pkg::OFS_FGAIN1}, 32'h0000_2000);
    bus.wr({2'h0, aicl_pkg::OFS_FGAIN0}, 16'h1234);
    rchk({2'h0, aicl_pkg::OFS_FGAIN0}, 32'h0000_4000);
    bus.wr(8'h30, 16'h5a5a);
    rchk(8'h30, 32'h0000_0000);
    feed(2'h1, 16'sd1000, 16'sd1000, 2'h0, 2'h0);
    bus.wr({2'h1, aicl_pkg::OFS_CTRL}, 16'h0110);
    feed(2'h1, 16'sd1000, 16'sd500, 2'h0, 2'h0);
    bus.wr({2'h1, aicl_pkg::OFS_CTRL}, 16'h0100);
    feed(2'h1, 16'sd1000, 16'sd1000, 2'h0, 2'h0);
    bus.wr({2'h2, aicl_pkg::OFS_UOFS}, 16'd100);
    bus.wr({2'h2, aicl_pkg::OFS_UGAIN}, 16'h6000);
    bus.wr({2'h2, aicl_pkg::OFS_SOFS}, 16'hffce);
    bus.wr({2'h2, aicl_pkg::OFS_SGAIN}, 16'h2000);
    feed(2'h2, 16'sd1100, 16'sd1100, 2'h0, 2'h0);
    bus.wr({2'h2, aicl_pkg::OFS_CTRL}, 16'h0018);
    feed(2'h2, 16'sd1100, stg(16'sd1100, 16'sd100, 16'sh6000, 1'b1), 2'h0, 2'h0);
    bus.wr({2'h2, aicl_pkg::OFS_CTRL}, 16'h0019);
    feed(2'h2, 16'sd1100, stg(stg(16'sd1100, 16'sd100, 16'sh6000, 1'b1), -16'sd50,
      16'sh2000, 1'b1), 2'h0, 2'h0);
    // user stage clips high, scaling then halves the clipped value plus 50
    feed(2'h2, 16'sd30000, 16'sd16408, 2'h0, 2'h0);
    `CHK("over", 1'b1, pd[2].over)
    `CHK("under", 1'b0, pd[2].under)
    rchk({2'h2, aicl_pkg::OFS_STAT}, 32'h0010_4018);
    feed(2'h2, -16'sd30000, -16'sd16359, 2'h0, 2'h0);
    `CHK("under", 1'b1, pd[2].under)
    bus.wr({2'h3, aicl_pkg::OFS_LIM1}, 16'h8000);
    bus.wr({2'h3, aicl_pkg::OFS_LIM2}, 16'd100);
    for (int s = 0; s < 2; s++)
    begin
      bus.wr({2'h3, aicl_pkg::OFS_CTRL}, s[0] ? 16'h0036 : 16'h0016);
      foreach (vals[i])
        feed(2'h3, vals[i], vals[i], cde(vals[i], 16'sh8000, s[0]),
          cde(vals[i], 16'sd100, s[0]));
    end
    bus.wr({2'h3, aicl_pkg::OFS_LIM1}, 16'h7fff);
    bus.wr({2'h3, aicl_pkg::OFS_CTRL}, 16'h0014);
    feed(2'h3, 16'sd32767, 16'sd32767, 2'h0, 2'h2);
    bus.wr({2'h3, aicl_pkg::OFS_CTRL}, 16'h0012);
    feed(2'h3, 16'sd32767, 16'sd32767, 2'h3, 2'h0);
    tally_and_finish();
  end
endmodule
